// [prom_prog_params.svh]
`ifndef PROM_PROG_PARAMS_SVH
`define PROM_PROG_PARAMS_SVH

`define ADDR_W 17
`define DATA_W 8
`define CLK_PERIOD_NS 10
`define T_PW_NS 200000
`define T_PW_CYC (`T_PW_NS / `CLK_PERIOD_NS)
`define T_OPW_NS 600000
`define T_OPW_MAX_NS 5250000
`define T_OPW_CYC (`T_OPW_NS / `CLK_PERIOD_NS)
`define T_SETUP_NS 2000
`define T_SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_HOLD_NS 2000
`define T_HOLD_CYC ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TOP_ADDR 17'h07fff
`define BLANK_BYTE 8'hff
`define RETRY_MAX 5'h19
`define FAIL_RUN_MAX 4'h3
`define MODE_PROM 3'h7

`endif

// [prom_prog_pkg.sv]
package prom_prog_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SETUP = 4'h1,
    ST_PULSE = 4'h2,
    ST_GAP = 4'h3,
    ST_VERIFY = 4'h4,
    ST_OPW_SETUP = 4'h5,
    ST_OPW = 4'h6,
    ST_DONE = 4'h7
  } prog_state_t;
endpackage

// [prom_programmer.sv]
`timescale 1ns/10ps
`include "prom_prog_params.svh"
// Summary of operation
// - write: chip enable low, output enable high, strobe low, data driven.
// - one byte per cycle with the byte algorithm, never page mode.
// - initial program pulse lasts 0.19 to 0.21 ms, nominally 0.2 ms.
// - over-programming pulse lasts at least 0.19 ms and at most 5.25 ms.
// - programming addresses are kept within the low 32 kbyte region.
// - image bytes for the upper unimplemented region must be all ones.
// - failures at several consecutive addresses abort the sequence.
// - the device is put in programming mode with all three mode pins high.
module prom_programmer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [16:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic busy,
  output logic done,
  output logic byte_fail,
  output logic aborted,
  output logic [7:0] read_back,
  output logic [2:0] mode_select_pins,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic program_strobe_n,
  output logic [16:0] prom_address_pins,
  output logic [7:0] prom_data_pins_o,
  output logic prom_data_pins_oe_n,
  input wire logic [7:0] prom_data_pins_i
);
  prom_prog_pkg::prog_state_t state_q;
  logic [19:0] cnt_q;
  logic [4:0] tries_q;
  logic [3:0] fail_run_q;
  logic [7:0] data_q;
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic match;
  logic cnt_done;
  logic upper;

  assign match = (sync2_q == data_q);
  assign cnt_done = (cnt_q == 20'h00000);
  assign upper = (wr_addr > `TOP_ADDR);
  assign busy = (state_q != prom_prog_pkg::ST_IDLE) &&
                (state_q != prom_prog_pkg::ST_DONE);
  assign mode_select_pins = `MODE_PROM;

  // data pin synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= prom_data_pins_i;
      sync2_q <= sync1_q;
    end
  end

  // sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= prom_prog_pkg::ST_IDLE;
      cnt_q <= 20'h00000;
      tries_q <= 5'h00;
      data_q <= 8'h00;
      prom_address_pins <= 17'h00000;
      done <= 1'b0;
      byte_fail <= 1'b0;
      read_back <= 8'h00;
    end else begin
      done <= 1'b0;
      unique case (state_q)
        prom_prog_pkg::ST_IDLE,
        prom_prog_pkg::ST_DONE: begin
          // upper region and blank bytes need no pulses
          if (start && !aborted) begin
            if (upper || wr_data == `BLANK_BYTE) begin
              done <= 1'b1;
              byte_fail <= upper && (wr_data != `BLANK_BYTE);
              state_q <= prom_prog_pkg::ST_DONE;
            end else begin
              prom_address_pins <= wr_addr;
              data_q <= wr_data;
              tries_q <= 5'h00;
              byte_fail <= 1'b0;
              cnt_q <= 20'(`T_SETUP_CYC);
              state_q <= prom_prog_pkg::ST_SETUP;
            end
          end
        end
        prom_prog_pkg::ST_SETUP: begin
          if (cnt_done) begin
            cnt_q <= 20'(`T_PW_CYC);
            tries_q <= tries_q + 5'h01;
            state_q <= prom_prog_pkg::ST_PULSE;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        prom_prog_pkg::ST_PULSE: begin
          if (cnt_done) begin
            // data still driven after the strobe rises
            cnt_q <= 20'(`T_HOLD_CYC);
            state_q <= prom_prog_pkg::ST_GAP;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        prom_prog_pkg::ST_GAP: begin
          if (cnt_done) begin
            cnt_q <= 20'(`T_SETUP_CYC);
            state_q <= prom_prog_pkg::ST_VERIFY;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        prom_prog_pkg::ST_VERIFY: begin
          if (!cnt_done) begin
            cnt_q <= cnt_q - 20'h00001;
          end else begin
            read_back <= sync2_q;
            if (match || tries_q == `RETRY_MAX) begin
              byte_fail <= !match;
              cnt_q <= 20'(`T_SETUP_CYC);
              state_q <= prom_prog_pkg::ST_OPW_SETUP;
            end else begin
              cnt_q <= 20'(`T_SETUP_CYC);
              state_q <= prom_prog_pkg::ST_SETUP;
            end
          end
        end
        prom_prog_pkg::ST_OPW_SETUP: begin
          if (cnt_done) begin
            cnt_q <= 20'(`T_OPW_CYC + `T_HOLD_CYC);
            state_q <= prom_prog_pkg::ST_OPW;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        prom_prog_pkg::ST_OPW: begin
          // tail of the count is the data hold
          if (cnt_done) begin
            done <= 1'b1;
            state_q <= prom_prog_pkg::ST_DONE;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        default: begin
          state_q <= prom_prog_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // consecutive failure tracking
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fail_run_q <= 4'h0;
      aborted <= 1'b0;
    end else if (done) begin
      if (byte_fail) begin
        fail_run_q <= fail_run_q + 4'h1;
        if (fail_run_q + 4'h1 >= `FAIL_RUN_MAX) begin
          aborted <= 1'b1;
        end
      end else begin
        fail_run_q <= 4'h0;
      end
    end
  end

  // pin drive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chip_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      program_strobe_n <= 1'b1;
      prom_data_pins_o <= 8'h00;
      prom_data_pins_oe_n <= 1'b1;
    end else begin
      chip_enable_n <= !busy;
      prom_data_pins_o <= data_q;
      unique case (state_q)
        prom_prog_pkg::ST_PULSE: begin
          output_enable_n <= 1'b1;
          program_strobe_n <= 1'b0;
          prom_data_pins_oe_n <= 1'b0;
        end
        prom_prog_pkg::ST_OPW: begin
          // strobe rises before the end so data outlasts it
          output_enable_n <= 1'b1;
          program_strobe_n <= (cnt_q <= 20'(`T_HOLD_CYC));
          prom_data_pins_oe_n <= 1'b0;
        end
        // controller drives data, device inhibited
        prom_prog_pkg::ST_SETUP,
        prom_prog_pkg::ST_GAP,
        prom_prog_pkg::ST_OPW_SETUP: begin
          output_enable_n <= 1'b1;
          program_strobe_n <= 1'b1;
          prom_data_pins_oe_n <= 1'b0;
        end
        prom_prog_pkg::ST_VERIFY: begin
          output_enable_n <= 1'b0;
          program_strobe_n <= 1'b1;
          prom_data_pins_oe_n <= 1'b1;
        end
        default: begin
          output_enable_n <= 1'b1;
          program_strobe_n <= 1'b1;
          prom_data_pins_oe_n <= 1'b1;
        end
      endcase
    end
  end
endmodule

// [prom_programmer_props.sv]
`timescale 1ns/10ps
module prom_programmer_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] mode_select_pins,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic program_strobe_n,
  input wire logic [16:0] prom_address_pins,
  input wire logic prom_data_pins_oe_n
);
  logic [19:0] low_q;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) low_q <= '0;
    else low_q <= program_strobe_n ? '0 : low_q + 20'h1;
  end
  AST_MODE: assert property (mode_select_pins == 3'h7)
    else $error("mode");
  AST_WR_OE: assert property (!program_strobe_n |-> output_enable_n
    && !prom_data_pins_oe_n) else $error("wr oe");
  AST_WR_CE: assert property (!program_strobe_n |-> !chip_enable_n)
    else $error("wr ce");
  AST_RD_HIZ: assert property (!output_enable_n |-> prom_data_pins_oe_n)
    else $error("rd hiz");
  AST_ADDR: assert property (!program_strobe_n |->
    prom_address_pins < 17'h08000) else $error("addr");
  AST_PW_MIN: assert property ($rose(program_strobe_n) |->
    low_q >= 20'h04a38) else $error("pw min");
  AST_PW_MAX: assert property (low_q <= 20'h802c8)
    else $error("pw max");
  AST_HOLD: assert property (!program_strobe_n && !$past(program_strobe_n)
    |-> $stable(prom_address_pins)) else $error("hold");
  AST_QUIET: assert property (chip_enable_n |-> program_strobe_n
    && output_enable_n && prom_data_pins_oe_n) else $error("quiet");
  AST_DATA_HOLD: assert property ($rose(program_strobe_n) |->
    !prom_data_pins_oe_n) else $error("data hold");
  AST_VERIFY: assert property (!output_enable_n |-> !chip_enable_n
    && program_strobe_n) else $error("verify");
endmodule
bind prom_programmer prom_programmer_props u_prom_programmer_props (.clk_sys,
  .rst, .mode_select_pins, .chip_enable_n, .output_enable_n,
  .program_strobe_n, .prom_address_pins, .prom_data_pins_oe_n);

// [prom_device_model.sv]
`timescale 1ns/10ps
module prom_device_model (
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic program_strobe_n,
  input wire logic [16:0] prom_address_pins,
  input wire logic [7:0] di,
  output logic [7:0] dq,
  output logic drive
);
  logic [7:0] mem [32768];
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign drive = !chip_enable_n && !output_enable_n && program_strobe_n;
  // released pins show inverted data
  assign dq = mem[prom_address_pins[14:0]] ^ {8{!drive}};
  always @(posedge program_strobe_n) begin
    if (!chip_enable_n && output_enable_n) mem[prom_address_pins[14:0]] &= di;
  end
endmodule

// [prom_programmer_tb.sv]
`timescale 1ns/10ps
module prom_programmer_tb;
  logic clk_sys, rst, start, busy, done, byte_fail, aborted, drive, seen_busy;
  logic chip_enable_n, output_enable_n, program_strobe_n, prom_data_pins_oe_n;
  logic [16:0] wr_addr, prom_address_pins, a;
  logic [7:0] wr_data, read_back, prom_data_pins_o, prom_data_pins_i, d, q;
  logic [2:0] mode_select_pins;
  int n_errors, checks_done;
  integer seed;
  assign prom_data_pins_i = prom_data_pins_oe_n ? q : prom_data_pins_o;
  prom_programmer u_prom_programmer (.clk_sys, .rst, .start, .wr_addr,
    .wr_data, .busy, .done, .byte_fail, .aborted, .read_back,
    .mode_select_pins, .chip_enable_n, .output_enable_n, .program_strobe_n,
    .prom_address_pins, .prom_data_pins_o, .prom_data_pins_oe_n,
    .prom_data_pins_i);
  prom_device_model u_prom_device_model (.chip_enable_n, .output_enable_n,
    .program_strobe_n, .prom_address_pins, .di(prom_data_pins_i), .dq(q),
    .drive);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(string s, logic [16:0] v, logic [16:0] e);
    checks_done++;
    if (v !== e) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", s, e, v);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic exp_fail(logic [16:0] ad, logic [7:0] dt);
    return (ad > 17'h07fff) && (dt != 8'hff);
  endfunction
  task automatic put(logic fail);
    int n;
    n = 0;
    start <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    start <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n == 1) seen_busy = busy;
    end while (done !== 1'b1 && n < 90000);
    check("done", done, 1'b1);
    if (done !== 1'b1) complete_run();
    check("fail", byte_fail, fail);
    $display("byte test done");
    @(posedge clk_sys);
  endtask
  initial begin
    rst = 1'b1;
    start = 1'b0;
    wr_addr = 17'h00000;
    wr_data = 8'h00;
    seen_busy = 1'b0;
    seed = 32'hfebf;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("mode", mode_select_pins, 3'h7);
    check("idle", {chip_enable_n, program_strobe_n, done, drive}, 4'hc);
    check("abort", {busy, aborted}, 2'h0);
    $display("reset test done");
    @(posedge clk_sys);
    repeat (3) begin
      a = 17'h08000 + 17'($unsigned($random(seed)) % 32'h18000);
      d = 8'($random(seed)) & 8'hfe;
      put(exp_fail(a, d));
    end
    @(negedge clk_sys);
    check("abort", aborted, 1'b1);
    @(posedge clk_sys);
    start <= 1'b1;
    wr_addr <= 17'h00010;
    wr_data <= 8'h00;
    repeat (4) begin
      @(negedge clk_sys);
      check("refused", {busy, done, chip_enable_n}, 3'h1);
    end
    @(posedge clk_sys);
    start <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("clear", {aborted, program_strobe_n}, 2'h1);
    $display("abort test done");
    @(posedge clk_sys);
    d = 8'hff;
    put(exp_fail(a, d));
    check("skip", seen_busy, 1'b0);
    a = 17'h00100;
    put(exp_fail(a, d));
    a = 17'($unsigned($random(seed)) % 32'h8000);
    d = 8'($random(seed)) & 8'h7f;
    put(exp_fail(a, d));
    check("busy", seen_busy, 1'b1);
    check("cell", u_prom_device_model.mem[a[14:0]], d);
    check("read", read_back, d);
    check("addr", prom_address_pins, a);
    @(negedge clk_sys);
    check("hiz", {drive, prom_data_pins_oe_n, chip_enable_n}, 3'h3);
    complete_run();
  end
endmodule
